// >>> hw/itb_regs.svh
/*
  port offsets, control word fields, status layout, reset values and
  synchroniser depth of the interval timer bus and counter core.
  assumes inclusion by bare name from the design files.
*/
`ifndef ITB_REGS_SVH
`define ITB_REGS_SVH

`define ITB_PORT_COUNTER0          2'h0
`define ITB_PORT_COUNTER1          2'h1
`define ITB_PORT_COUNTER2          2'h2
`define ITB_PORT_MODE_PROG         2'h3

`define ITB_CW_SELECT_MSB          7
`define ITB_CW_SELECT_LSB          6
`define ITB_CW_FORMAT_MSB          5
`define ITB_CW_FORMAT_LSB          4
`define ITB_CW_MODE_MSB            3
`define ITB_CW_MODE_LSB            1
`define ITB_CW_BCD_BIT             0

`define ITB_SELECT_READBACK        2'h3

`define ITB_FMT_LATCH              2'h0
`define ITB_FMT_LOW                2'h1
`define ITB_FMT_HIGH               2'h2
`define ITB_FMT_BOTH               2'h3

`define ITB_MODE_TERMINAL          3'h0
`define ITB_RATE_LOW_BITS          2'h2
`define ITB_SQUARE_LOW_BITS        2'h3

`define ITB_RB_COUNT_INHIBIT_BIT   5
`define ITB_RB_STATUS_INHIBIT_BIT  4
`define ITB_RB_SELECT_LSB          1

`define ITB_STATUS_OUT_BIT         7
`define ITB_STATUS_NULL_BIT        6

`define ITB_RESET_CTRL             6'h00
`define ITB_RESET_COUNT            16'h0000
`define ITB_RESET_PIN_IDLE         3'h7

`define ITB_SYNC_STAGES            2

`endif

// >>> hw/itb_pkg.sv
/*
  types of the interval timer bus and counter core: bus state machine,
  per-counter state and whole-core state.
  assumes nothing beyond a SystemVerilog compiler.
*/
package itb_pkg;

  typedef enum logic [2:0] {
    bus_idle  = 3'b001,
    bus_write = 3'b010,
    bus_read  = 3'b100
  } itb_bus_state_t;

  typedef struct packed {
    logic [5:0]  ctrl;
    logic [15:0] count;
    logic [7:0]  preset_holding_low;
    logic [7:0]  preset_holding_high;
    logic [15:0] snapshot_latch;
    logic        snap_held;
    logic [7:0]  status;
    logic        status_held;
    logic        null_count;
    logic        out;
    logic        wr_high_next;
    logic        rd_high_next;
    logic        load_pending;
    logic        clk_prev;
  } itb_chan_t;

  typedef struct packed {
    itb_bus_state_t  bus;
    logic [1:0]      addr;
    logic [7:0]      wdata;
    logic [7:0]      data_out;
    logic            data_oe;
    itb_chan_t [2:0] ch;
  } itb_core_t;

endpackage

// >>> hw/itb_sync.sv
/*
  multi-stage synchroniser for a group of pin inputs.
  assumes the pins change asynchronously to clk; only the last stage is read.
*/
`timescale 1ns/100ps
`include "itb_regs.svh"
module itb_sync #(
  parameter int                STAGES      = `ITB_SYNC_STAGES,
  parameter int                WIDTH       = 1,
  parameter logic [WIDTH-1:0]  RESET_VALUE = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [STAGES-1:0][WIDTH-1:0] stage;
  } itb_sync_state_t;

  itb_sync_state_t state;
  itb_sync_state_t next_state;

  if (STAGES < 2) begin : g_check
    $error("itb_sync needs at least two stages");
  end

  always_comb begin
    next_state = state;
    next_state.stage = {state.stage[STAGES-2:0], d};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state.stage <= {STAGES{RESET_VALUE}};
    end else begin
      state <= next_state;
    end
  end

  assign q = state.stage[STAGES-1];
endmodule

// >>> hw/itb_core.sv
/*
  host bus interface and three counter datapaths of the interval timer.
  assumes host strobes, address, data and counter pins are asynchronous
  to clk and are held for several clk periods; the data pin is resolved
  from data_out and data_oe outside this module.
*/
// How it works
// - strobes ignored unless chip select low
// - port select picks counter or control
// - port 11 write stores control word
// - control port never readable by host
// - byte-wide data path with output enable
// - three identical independent counter copies
// - sixteen-bit presettable down counter per counter
// - snapshot follows count, holds until read
// - snapshot read out one byte at time
// - reads return snapshot, never counter itself
// - writes fill preset bytes, never counter
// - both preset bytes loaded together later
// - control word clears both preset bytes
// - status captures control, output, null flag
// - host programs counters; reset state defined
// - control top bits pick counter or readback
// - format field latch, low, high, both
`timescale 1ns/100ps
`include "itb_regs.svh"
module itb_core #(
  parameter int NUM_COUNTERS = 3
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [1:0] port_select,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic [2:0] counter_clk,
  input  wire logic [2:0] counter_gate,
  output logic      [2:0] counter_out
);

  if (NUM_COUNTERS != 3) begin : g_check
    $error("port decode serves exactly three counters");
  end

  itb_pkg::itb_core_t state;
  itb_pkg::itb_core_t next_state;

  logic       cs_n_s;
  logic       rd_n_s;
  logic       wr_n_s;
  logic [1:0] port_s;
  logic [7:0] data_s;
  logic [2:0] clk_s;
  logic [2:0] gate_s;

  // every pin passes the synchroniser before any decode
  itb_sync #(
    .STAGES      (`ITB_SYNC_STAGES),
    .WIDTH       (19),
    .RESET_VALUE ({`ITB_RESET_PIN_IDLE, 16'h0000})
  ) u_pin_sync (
    .clk (clk),
    .rst (rst),
    .d   ({cs_n, rd_n, wr_n, port_select, data_in, counter_clk, counter_gate}),
    .q   ({cs_n_s, rd_n_s, wr_n_s, port_s, data_s, clk_s, gate_s})
  );

  function automatic logic [7:0] read_byte(input itb_pkg::itb_chan_t c);
    if (c.status_held) begin
      read_byte = c.status;
    end else if (c.rd_high_next) begin
      read_byte = c.snapshot_latch[15:8];
    end else begin
      read_byte = c.snapshot_latch[7:0];
    end
  endfunction

  function automatic logic [1:0] fmt_of(input logic [5:0] ctrl);
    fmt_of = ctrl[`ITB_CW_FORMAT_MSB:`ITB_CW_FORMAT_LSB];
  endfunction

  function automatic logic [2:0] mode_of(input logic [5:0] ctrl);
    mode_of = ctrl[`ITB_CW_MODE_MSB:`ITB_CW_MODE_LSB];
  endfunction

  always_comb begin
    logic                sel_act;
    logic                rd_act;
    logic                wr_act;
    logic                wr_commit;
    logic                rd_commit;
    logic [7:0]          cw;
    logic [1:0]          cw_sel;
    logic [1:0]          cw_fmt;
    logic [2:0]          program_cmd;
    logic [2:0]          latch_count;
    logic [2:0]          latch_status;
    logic [2:0]          count_we;
    logic [2:0]          read_done;
    logic                tick;
    logic                write_done;
    logic [2:0]          mode;
    logic [1:0]          fmt;
    itb_pkg::itb_chan_t  c;
    next_state   = state;
    sel_act      = 1'b0;
    rd_act       = 1'b0;
    wr_act       = 1'b0;
    wr_commit    = 1'b0;
    rd_commit    = 1'b0;
    cw           = state.wdata;
    cw_sel       = cw[`ITB_CW_SELECT_MSB:`ITB_CW_SELECT_LSB];
    cw_fmt       = cw[`ITB_CW_FORMAT_MSB:`ITB_CW_FORMAT_LSB];
    program_cmd  = 3'h0;
    latch_count  = 3'h0;
    latch_status = 3'h0;
    count_we     = 3'h0;
    read_done    = 3'h0;
    tick         = 1'b0;
    write_done   = 1'b0;
    mode         = 3'h0;
    fmt          = 2'h0;
    c            = state.ch[0];

    sel_act = ~cs_n_s;
    rd_act  = sel_act & ~rd_n_s;
    wr_act  = sel_act & ~wr_n_s;

    // access taken on strobe release, so the last stable byte is used
    case (state.bus)
      itb_pkg::bus_idle: begin
        if (wr_act) begin
          next_state.bus   = itb_pkg::bus_write;
          next_state.addr  = port_s;
          next_state.wdata = data_s;
        end else if (rd_act) begin
          next_state.bus  = itb_pkg::bus_read;
          next_state.addr = port_s;
        end
      end
      itb_pkg::bus_write: begin
        if (wr_act) begin
          next_state.wdata = data_s;
        end else begin
          wr_commit      = 1'b1;
          next_state.bus = itb_pkg::bus_idle;
        end
      end
      itb_pkg::bus_read: begin
        if (!rd_act) begin
          rd_commit      = 1'b1;
          next_state.bus = itb_pkg::bus_idle;
        end
      end
      default: begin
        next_state.bus = itb_pkg::bus_idle;
      end
    endcase

    // control word decode
    if (wr_commit && state.addr == `ITB_PORT_MODE_PROG) begin
      if (cw_sel == `ITB_SELECT_READBACK) begin
        for (int i = 0; i < 3; i++) begin
          if (cw[`ITB_RB_SELECT_LSB + i]) begin
            latch_count[i]  = ~cw[`ITB_RB_COUNT_INHIBIT_BIT];
            latch_status[i] = ~cw[`ITB_RB_STATUS_INHIBIT_BIT];
          end
        end
      end else begin
        for (int i = 0; i < 3; i++) begin
          if (cw_sel == 2'(i)) begin
            if (cw_fmt == `ITB_FMT_LATCH) begin
              latch_count[i] = 1'b1;
            end else begin
              program_cmd[i] = 1'b1;
            end
          end
        end
      end
    end

    for (int i = 0; i < 3; i++) begin
      if (wr_commit && state.addr == 2'(i)) begin
        count_we[i] = 1'b1;
      end
      if (rd_commit && state.addr == 2'(i)) begin
        read_done[i] = 1'b1;
      end
    end

    // identical logic per counter, no shared state between them
    for (int i = 0; i < 3; i++) begin
      c    = state.ch[i];
      mode = mode_of(c.ctrl);
      fmt  = fmt_of(c.ctrl);
      tick = clk_s[i] & ~c.clk_prev;
      next_state.ch[i].clk_prev = clk_s[i];

      if (tick) begin
        if (c.load_pending) begin
          // one transfer of both bytes, on the next counter clock
          next_state.ch[i].count        = {c.preset_holding_high, c.preset_holding_low};
          next_state.ch[i].load_pending = 1'b0;
          next_state.ch[i].null_count   = 1'b0;
        end else if (gate_s[i]) begin
          if ((mode[1:0] == `ITB_RATE_LOW_BITS || mode[1:0] == `ITB_SQUARE_LOW_BITS)
              && c.count == 16'h0001) begin
            next_state.ch[i].count = {c.preset_holding_high, c.preset_holding_low};
            if (mode[1:0] == `ITB_SQUARE_LOW_BITS) begin
              next_state.ch[i].out = ~c.out;
            end
          end else begin
            next_state.ch[i].count = c.count - 16'h0001;
          end
          // simplified waveforms: terminal high, rate pulse, strobe low at zero
          if (mode == `ITB_MODE_TERMINAL && c.count == 16'h0001) begin
            next_state.ch[i].out = 1'b1;
          end else if (mode[1:0] == `ITB_RATE_LOW_BITS) begin
            next_state.ch[i].out = (c.count != 16'h0002);
          end else if (mode[2] && !mode[1]) begin
            next_state.ch[i].out = (c.count != 16'h0001);
          end
        end
      end

      // snapshot follows the counter unless frozen
      if (!c.snap_held) begin
        next_state.ch[i].snapshot_latch = c.count;
      end
      if (latch_count[i] && !c.snap_held) begin
        next_state.ch[i].snap_held      = 1'b1;
        next_state.ch[i].snapshot_latch = c.count;
      end
      if (latch_status[i] && !c.status_held) begin
        next_state.ch[i].status      = {c.out, c.null_count, c.ctrl};
        next_state.ch[i].status_held = 1'b1;
      end

      // status byte goes out first, then the count bytes
      if (read_done[i]) begin
        if (c.status_held) begin
          next_state.ch[i].status_held = 1'b0;
        end else if (fmt == `ITB_FMT_BOTH) begin
          next_state.ch[i].rd_high_next = ~c.rd_high_next;
          if (c.rd_high_next) begin
            next_state.ch[i].snap_held = 1'b0;
          end
        end else begin
          next_state.ch[i].snap_held = 1'b0;
        end
      end

      // a count write completing the preset after the load in the same cycle keeps null set
      if (count_we[i]) begin
        if (c.wr_high_next) begin
          next_state.ch[i].preset_holding_high = state.wdata;
        end else begin
          next_state.ch[i].preset_holding_low = state.wdata;
        end
        write_done = (fmt != `ITB_FMT_BOTH) || c.wr_high_next;
        if (fmt == `ITB_FMT_BOTH) begin
          next_state.ch[i].wr_high_next = ~c.wr_high_next;
        end
        if (write_done) begin
          next_state.ch[i].load_pending = 1'b1;
          next_state.ch[i].null_count   = 1'b1;
        end
      end

      // programming overrides other updates on this counter except count, snapshot, status byte and clk_prev
      if (program_cmd[i]) begin
        next_state.ch[i].ctrl                = cw[5:0];
        next_state.ch[i].preset_holding_low  = 8'h00;
        next_state.ch[i].preset_holding_high = 8'h00;
        next_state.ch[i].wr_high_next        = (cw_fmt == `ITB_FMT_HIGH);
        next_state.ch[i].rd_high_next        = (cw_fmt == `ITB_FMT_HIGH);
        next_state.ch[i].null_count          = 1'b1;
        next_state.ch[i].load_pending        = 1'b0;
        next_state.ch[i].snap_held           = 1'b0;
        next_state.ch[i].status_held         = 1'b0;
        next_state.ch[i].out                 =
          (cw[`ITB_CW_MODE_MSB:`ITB_CW_MODE_LSB] != `ITB_MODE_TERMINAL);
      end
    end

    // output buffer enabled only for a selected counter read
    next_state.data_oe = (next_state.bus == itb_pkg::bus_read)
                         && (next_state.addr != `ITB_PORT_MODE_PROG);
    case (next_state.addr)
      `ITB_PORT_COUNTER0: next_state.data_out = read_byte(state.ch[0]);
      `ITB_PORT_COUNTER1: next_state.data_out = read_byte(state.ch[1]);
      `ITB_PORT_COUNTER2: next_state.data_out = read_byte(state.ch[2]);
      default:            next_state.data_out = 8'h00;
    endcase
  end

  // defined reset state even though software must still program each counter
  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= '0;
      state.bus <= itb_pkg::bus_idle;
      for (int i = 0; i < 3; i++) begin
        state.ch[i].ctrl     <= `ITB_RESET_CTRL;
        state.ch[i].count    <= `ITB_RESET_COUNT;
        state.ch[i].clk_prev <= 1'b0;
      end
    end else begin
      state <= next_state;
    end
  end

  assign data_out = state.data_out;
  assign data_oe  = state.data_oe;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      counter_out[i] = state.ch[i].out;
    end
  end
endmodule

// >>> verif/itb_core_chk.sv
/*
  port assertions for the timer core.
  assumes bind onto itb_core; host holds strobes several clk periods.
*/
`timescale 1ns/100ps
module itb_core_chk #(
  parameter int NUM_COUNTERS = 3
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic [1:0] port_select,
  input wire logic       data_oe,
  input wire logic [2:0] counter_clk,
  input wire logic [2:0] counter_gate,
  input wire logic [2:0] counter_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd_ctr;
    (!cs_n && !rd_n && port_select != 2'h3)[*4];
  endsequence
  sequence s_rd_ctl;
    (!cs_n && !rd_n && port_select == 2'h3)[*4];
  endsequence
  // pins pass two sync stages, so quiet must last longer than that
  sequence s_quiet;
    ($stable(counter_clk) && $stable(counter_gate) && wr_n)[*8];
  endsequence
  a_oe_from_strobe: assert property (
    $rose(data_oe) |-> !$past(cs_n, 2) && !$past(rd_n, 2))
    else $error("data driven without selected read");
  a_cs_gates_oe: assert property (cs_n[*5] |-> !data_oe)
    else $error("data driven while deselected");
  a_oe_port: assert property (
    $rose(data_oe) |-> $past(port_select, 2) != 2'h3)
    else $error("control port driven");
  a_ctl_silent: assert property (s_rd_ctl |=> !data_oe)
    else $error("control port read drives bus");
  a_read_drives: assert property (s_rd_ctr |=> data_oe)
    else $error("counter read not answered");
  a_oe_release: assert property (rd_n[*5] |-> !data_oe)
    else $error("bus held after read");
  a_write_silent: assert property ((!wr_n)[*2] |-> !data_oe)
    else $error("bus driven during write");
  a_out_holds: assert property (s_quiet |=> $stable(counter_out))
    else $error("output moved without counter clock");
  a_reset_quiet: assert property (
    @(posedge clk) disable iff (1'b0) rst |=> !data_oe && counter_out == 3'h0)
    else $error("reset state wrong");
endmodule

bind itb_core itb_core_chk #(.NUM_COUNTERS(NUM_COUNTERS)) i_chk (
  .clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .port_select(port_select), .data_oe(data_oe), .counter_clk(counter_clk),
  .counter_gate(counter_gate), .counter_out(counter_out));

// >>> verif/itb_host.sv
/*
  host cpu model: byte-wide peripheral bus master.
  assumes callers use acc; pins move 1 ns after a rising clk edge.
*/
`timescale 1ns/100ps
module itb_host (
  input  wire logic       clk,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [1:0] port_select,
  output logic      [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  wire [7:0] data_bus = data_oe ? data_out : 8'hzz;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    port_select = 2'h0;
    data_in = 8'h00;
  end
  // 6 clk strobe and 6 clk gap: the core needs 2 of each to sync
  task automatic acc(input logic sel, input logic wr, input logic [1:0] a,
                     input logic [7:0] d, output logic [7:0] q, output logic oe);
    @(posedge clk) #1;
    port_select = a;
    data_in = d;
    cs_n = !sel;
    wr_n = !wr;
    rd_n = wr;
    repeat (6) @(posedge clk);
    q = data_bus;
    oe = data_oe;
    #1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = ~d;
    repeat (6) @(posedge clk);
  endtask
endmodule

// >>> verif/testbench.sv
/*
  self-checking bench for the timer core.
  assumes itb_host as the cpu and itb_core_chk bound to the core.
*/
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
      mismatches++; \
    end \
  end
module testbench;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] counter_clk = 3'h0;
  logic [2:0] counter_gate = 3'h0;
  wire        cs_n;
  wire        rd_n;
  wire        wr_n;
  wire  [1:0] port_select;
  wire  [7:0] data_in;
  wire  [7:0] data_out;
  wire        data_oe;
  wire  [2:0] counter_out;
  logic [7:0] q;
  logic       oe;
  int         mismatches = 0;
  int         samples_checked = 0;
  always #20 clk = ~clk;
  itb_host i_host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_select(port_select), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  itb_core i_dut (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_select(port_select), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .counter_clk(counter_clk), .counter_gate(counter_gate), .counter_out(counter_out));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_host.acc(1'b1, 1'b1, a, d, q, oe);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    i_host.acc(1'b1, 1'b0, a, 8'h00, q, oe);
    `CHK("read enable", 1'b1, oe)
    `CHK("read data", exp, q)
  endtask
  // slow against clk so the synchroniser sees every edge
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) #1;
      counter_clk = 3'h7;
      repeat (4) @(posedge clk);
      #1;
      counter_clk = 3'h0;
      repeat (4) @(posedge clk);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK("out after reset", 3'h0, counter_out)
    wr(2'h3, 8'h30);
    wr(2'h0, 8'h34);
    wr(2'h0, 8'h12);
    pulse(1);
    rd(2'h0, 8'h34);
    rd(2'h0, 8'h12);
    $display("test load done");
    wr(2'h3, 8'h00);
    #1;
    counter_gate = 3'h1;
    pulse(3);
    rd(2'h0, 8'h34);
    rd(2'h0, 8'h12);
    rd(2'h0, 8'h31);
    rd(2'h0, 8'h12);
    #1;
    counter_gate = 3'h0;
    $display("test latch done");
    i_host.acc(1'b0, 1'b1, 2'h3, 8'h10, q, oe);
    i_host.acc(1'b0, 1'b0, 2'h0, 8'h00, q, oe);
    `CHK("deselected read", 1'b0, oe)
    rd(2'h0, 8'h31);
    rd(2'h0, 8'h12);
    i_host.acc(1'b1, 1'b0, 2'h3, 8'h00, q, oe);
    `CHK("control read", 1'b0, oe)
    $display("test select done");
    wr(2'h3, 8'ha0);
    wr(2'h2, 8'h5c);
    pulse(1);
    rd(2'h2, 8'h5c);
    wr(2'h3, 8'h90);
    wr(2'h2, 8'h22);
    pulse(1);
    wr(2'h3, 8'hb0);
    rd(2'h2, 8'h22);
    rd(2'h2, 8'h00);
    wr(2'h3, 8'he8);
    rd(2'h2, 8'h70);
    wr(2'h3, 8'hd8);
    rd(2'h2, 8'h22);
    rd(2'h2, 8'h00);
    $display("test formats done");
    wr(2'h3, 8'h50);
    wr(2'h1, 8'h03);
    pulse(1);
    `CHK("out before count", 3'h0, counter_out)
    #1;
    counter_gate = 3'h2;
    pulse(3);
    `CHK("out at zero", 3'h2, counter_out)
    rd(2'h1, 8'h00);
    $display("test count done");
    // counter 0 in square mode beside counter 1 still in terminal mode
    #1;
    counter_gate = 3'h1;
    wr(2'h3, 8'h16);
    wr(2'h0, 8'h02);
    pulse(1);
    `CHK("square start", 3'h3, counter_out)
    pulse(2);
    `CHK("square toggle", 3'h2, counter_out)
    pulse(2);
    `CHK("square back", 3'h3, counter_out)
    $display("test square done");
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule
